// ==== rtl/headpos_device.sv ====
// head positioner processor interface: track follower timing, seek counter, retract latches
`timescale 1ns/100ps
module headpos_device
    import headpos_pkg::*;
#(
    parameter int RS_W = 4,
    parameter int DIBITS_PER_SECTOR = 143,
    parameter int SECTORS_PER_REV = 93
) (
    // clock and reset
    input wire logic ref_clk_i,
    input wire logic reset_n_i,
    // processor link
    headpos_if.device link,
    // servo timing inputs
    input wire logic servo_dibit_i,
    input wire logic sector_sync_i,
    input wire logic quarter_track_crossing_pulse_i,
    // asynchronous status inputs
    input wire logic gain_fault_i,
    input wire logic servo_head_good_i,
    input wire logic [RS_W-1:0] retract_src_i,
    // timing outputs
    output logic index_pulse_n_o,
    output logic sector_start_out_n_o,
    // servo outputs
    output logic [DTG_W-1:0] distance_to_go_o,
    output logic linear_mode_o,
    output logic fast_position_switch_enable_n_o,
    output logic slow_position_switch_enable_n_o,
    output logic track_follower_fault_o,
    output logic retract_active_o
);
    function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [OFS_W-1:0] ofs);
        hit = (a[ADDR_W-1:OFS_W] == DEV_PAGE) && (a[OFS_W-1:0] == ofs);
    endfunction : hit

    logic [DATA_W-1:0] ctrl_q, seek_q, dtg_lo_q, rdata_q, rdata_d;
    logic rd_q;
    logic [DTG_W-1:0] dtg_q;
    logic half_q;
    logic [7:0] dibit_cnt_q;
    logic [15:0] sector_dibit_q;
    logic [7:0] rev_cnt_q;
    logic sos_pulse_q, index_q, sync_seen_q;
    sync_seq_e seq_q, seq_d;
    logic presence_q, test_q, scpr_q, pler_q, gflt_q, tfflt_q;
    logic inl_q, latch_q;
    logic [1:0] gf_sync_q, hg_sync_q;
    logic [RS_W-1:0] rs_meta_q, rs_q;

    // decode
    logic wr_ctrl, wr_seek, wr_lo, wr_hi, wr_rt;
    logic clr, isync, sos_en, resync, any_retract;
    logic dibit_wrap, dibit_near, sector_wrap, dtg_step, dtg_ld;
    assign wr_ctrl = link.wr_stb && hit(link.addr, REG_TF_CTRL);
    assign wr_seek = link.wr_stb && hit(link.addr, REG_SEEK_CTRL);
    assign wr_lo = link.wr_stb && hit(link.addr, REG_DTG_LO);
    assign wr_hi = link.wr_stb && hit(link.addr, REG_DTG_HI);
    assign wr_rt = link.wr_stb && hit(link.addr, REG_RETRACT);
    assign clr = ctrl_q[TF_CLR_BIT];
    assign isync = ctrl_q[TF_ISYNC_BIT];
    assign sos_en = ctrl_q[TF_SOSEN_BIT];
    assign resync = ctrl_q[TF_RESYNC_BIT];
    assign any_retract = |rs_q;
    assign link.actuator_board_select_n = !(link.addr[ADDR_W-1:OFS_W] == ACT_PAGE);

    // register read mux, data driven the cycle after the strobe
    always_comb begin
        rdata_d = '0;
        case (link.addr[OFS_W-1:0])
            REG_TF_CTRL: rdata_d = ctrl_q;
            REG_TF_STAT: rdata_d = {seq_q == SEQ_MISS, hg_sync_q[1], tfflt_q, gflt_q,
                                    pler_q, scpr_q, !test_q, presence_q};
            REG_DTG_LO: rdata_d = dtg_q[DATA_W-1:0];
            REG_DTG_HI: rdata_d = {5'h00, dtg_q[DTG_W-1:DATA_W]};
            REG_SEEK_CTRL: rdata_d = seek_q;
            REG_RETRACT: rdata_d = {5'h00, retract_active_o, latch_q, inl_q};
            default: rdata_d = '0;
        endcase
    end

    always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            rd_q <= 1'b0;
            rdata_q <= '0;
        end else begin
            rd_q <= link.rd_stb && (link.addr[ADDR_W-1:OFS_W] == DEV_PAGE);
            rdata_q <= rdata_d;
        end
    end
    assign link.dev_data = rdata_q;
    assign link.dev_data_oe = rd_q;

    // control registers
    always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            ctrl_q <= TF_CTRL_RST;
            seek_q <= SEEK_CTRL_RST;
            dtg_lo_q <= '0;
        end else begin
            if (wr_ctrl) ctrl_q <= link.data_bus;
            if (wr_seek) seek_q <= link.data_bus;
            if (wr_lo) dtg_lo_q <= link.data_bus;
        end
    end
    assign linear_mode_o = seek_q[SK_LIN_BIT];
    assign fast_position_switch_enable_n_o = !seek_q[SK_PSTN_BIT]
                                             || seek_q[SK_LIN_BIT];
    assign slow_position_switch_enable_n_o = !seek_q[SK_PSTN_BIT]
                                             || !seek_q[SK_LIN_BIT];

    // status synchronisers
    always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            gf_sync_q <= '0;
            hg_sync_q <= '0;
            rs_meta_q <= '0;
            rs_q <= '0;
        end else begin
            gf_sync_q <= {gf_sync_q[0], gain_fault_i};
            hg_sync_q <= {hg_sync_q[0], servo_head_good_i};
            rs_meta_q <= retract_src_i;
            rs_q <= rs_meta_q;
        end
    end

    // distance to go: counts every second quarter crossing via the half track phase, or every crossing when SK_FCE_BIT is set
    assign dtg_ld = wr_hi;
    assign dtg_step = seek_q[SK_DTGCE_BIT] && quarter_track_crossing_pulse_i
                      && (half_q || seek_q[SK_FCE_BIT]);
    always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            dtg_q <= '0;
            half_q <= 1'b0;
        end else if (dtg_ld) begin
            dtg_q <= {link.data_bus[DTG_HI_W-1:0], dtg_lo_q};
            half_q <= 1'b0;
        end else if (seek_q[SK_DTGCE_BIT] && quarter_track_crossing_pulse_i) begin
            half_q <= !(half_q || seek_q[SK_FCE_BIT]);
            if (dtg_step && dtg_q != '0) dtg_q <= dtg_q - 11'h001;
        end
    end
    assign distance_to_go_o = dtg_q;

    // dibit timing, realigned by every recovered dibit
    assign dibit_wrap = (dibit_cnt_q == 8'(DIBIT_CYCLES - 1));
    assign dibit_near = (dibit_cnt_q < 8'(LOCK_WIN))
                        || (dibit_cnt_q > 8'(DIBIT_CYCLES - 1 - LOCK_WIN));
    assign sector_wrap = dibit_wrap && (sector_dibit_q == 16'(DIBITS_PER_SECTOR - 1));
    always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            dibit_cnt_q <= '0;
            sector_dibit_q <= '0;
        end else begin
            if (servo_dibit_i) dibit_cnt_q <= '0;
            else if (dibit_wrap) dibit_cnt_q <= '0;
            else dibit_cnt_q <= dibit_cnt_q + 8'h01;
            if (sector_sync_i && seq_q == SEQ_HUNT) sector_dibit_q <= '0;
            else if (sector_wrap) sector_dibit_q <= '0;
            else if (dibit_wrap) sector_dibit_q <= sector_dibit_q + 16'h0001;
        end
    end

    // sector sync sequencer
    always_comb begin
        seq_d = seq_q;
        case (seq_q)
            SEQ_HUNT: if (sector_sync_i) seq_d = SEQ_LOCK;
            SEQ_LOCK: if (sector_wrap && !sync_seen_q && !sector_sync_i) seq_d = SEQ_MISS;
            SEQ_MISS: if (resync || clr) seq_d = SEQ_HUNT;
            default: seq_d = SEQ_HUNT;
        endcase
    end

    // revolution counter and sector pulse
    always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            seq_q <= SEQ_HUNT;
            sync_seen_q <= 1'b0;
            rev_cnt_q <= '0;
            sos_pulse_q <= 1'b0;
            index_q <= 1'b0;
        end else begin
            seq_q <= seq_d;
            if (sector_wrap) sync_seen_q <= 1'b0;
            else if (sector_sync_i) sync_seen_q <= 1'b1;
            sos_pulse_q <= sector_wrap;
            index_q <= 1'b0;
            if (isync) begin
                rev_cnt_q <= '0;
            end else if (sector_wrap) begin
                if (rev_cnt_q == 8'(SECTORS_PER_REV - 1)) begin
                    rev_cnt_q <= '0;
                    index_q <= 1'b1;
                end else begin
                    rev_cnt_q <= rev_cnt_q + 8'h01;
                end
            end
        end
    end
    assign index_pulse_n_o = !index_q;
    assign sector_start_out_n_o = !(sos_pulse_q && sos_en);

    // sticky track follower flags
    always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            presence_q <= 1'b0;
            test_q <= 1'b0;
            scpr_q <= 1'b0;
            pler_q <= 1'b0;
            gflt_q <= 1'b0;
            tfflt_q <= 1'b0;
        end else begin
            if (clr) presence_q <= 1'b0;
            else if (sos_pulse_q) presence_q <= 1'b1;
            if (clr) test_q <= 1'b0;
            else if (sos_pulse_q && sos_en) test_q <= 1'b1;
            if (sector_sync_i) scpr_q <= 1'b1;
            else if (clr) scpr_q <= 1'b0;
            if (servo_dibit_i && !dibit_near) pler_q <= 1'b1;
            else if (clr) pler_q <= 1'b0;
            if (gf_sync_q[1]) gflt_q <= 1'b1;
            else if (clr) gflt_q <= 1'b0;
            if (gf_sync_q[1]) tfflt_q <= 1'b1;
            else if (clr) tfflt_q <= 1'b0;
        end
    end
    assign track_follower_fault_o = tfflt_q;

    // emergency retract latches
    always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            inl_q <= 1'b0;
            latch_q <= 1'b0;
        end else begin
            if (any_retract) inl_q <= 1'b1;
            else if (wr_rt && link.data_bus[RT_CLIP_BIT]) inl_q <= 1'b0;
            if (any_retract) latch_q <= 1'b1;
            else if (link.retract_latch_clear) latch_q <= 1'b0;
        end
    end
    assign retract_active_o = latch_q || any_retract;
endmodule : headpos_device

// ==== rtl/headpos_pkg.sv ====
// constants, register map and types shared by both ends of the head positioner link
package headpos_pkg;
    localparam int ADDR_W = 12;
    localparam int DATA_W = 8;
    localparam int PAGE_W = 8;
    localparam int OFS_W = 4;
    localparam int DTG_W = 11;
    localparam int DTG_HI_W = 3;
    localparam int DT_W = 3;
    // address pages (addr[11:4])
    localparam logic [7:0] DEV_PAGE = 8'h01;
    localparam logic [7:0] ACT_PAGE = 8'h02;
    localparam logic [7:0] HOST_PAGE = 8'h03;
    // device register offsets
    localparam logic [3:0] REG_TF_CTRL = 4'h0;
    localparam logic [3:0] REG_TF_STAT = 4'h1;
    localparam logic [3:0] REG_DTG_LO = 4'h2;
    localparam logic [3:0] REG_DTG_HI = 4'h3;
    localparam logic [3:0] REG_SEEK_CTRL = 4'h4;
    localparam logic [3:0] REG_RETRACT = 4'h5;
    // host local register offset
    localparam logic [3:0] REG_HOST_CTRL = 4'h0;
    // tf control bits
    localparam int TF_CLR_BIT = 0;
    localparam int TF_ISYNC_BIT = 1;
    localparam int TF_SOSEN_BIT = 2;
    localparam int TF_RESYNC_BIT = 3;
    // seek control bits
    localparam int SK_DTGCE_BIT = 0;
    localparam int SK_FCE_BIT = 1;
    localparam int SK_LIN_BIT = 2;
    localparam int SK_PSTN_BIT = 3;
    // retract register bits
    localparam int RT_CLIP_BIT = 0;
    localparam int RT_INL_BIT = 0;
    localparam int RT_LATCH_BIT = 1;
    localparam int RT_ACTIVE_BIT = 2;
    // host control bits
    localparam int HC_CUL_BIT = 3;
    localparam int HC_RLC_BIT = 4;
    localparam int HC_CULACT_BIT = 7;
    // reset values
    localparam logic [7:0] TF_CTRL_RST = 8'h00;
    localparam logic [7:0] SEEK_CTRL_RST = 8'h08;
    localparam logic [2:0] DT_RST = 3'h0;
    // timing chain
    localparam int REF_FREQ_KHZ = 200000;
    localparam int SERVO_FREQ_KHZ = 800;
    localparam int VCO_FREQ_KHZ = 12800;
    localparam int DIBIT_CYCLES = REF_FREQ_KHZ / SERVO_FREQ_KHZ;
    localparam int LOCK_WIN = REF_FREQ_KHZ / VCO_FREQ_KHZ;
    localparam int CLK_PERIOD_NS = 5;
    localparam int CUL_TIME_US = 20000;
    localparam int CUL_CYCLES = (CUL_TIME_US * 1000) / CLK_PERIOD_NS;

    typedef enum logic [1:0] {
        SEQ_HUNT = 2'b00,
        SEQ_LOCK = 2'b01,
        SEQ_MISS = 2'b11
    } sync_seq_e;
endpackage : headpos_pkg

// ==== rtl/headpos_if.sv ====
// processor bus and loose control pins between the processor end and the positioner
`timescale 1ns/100ps
interface headpos_if;
    import headpos_pkg::*;
    logic [ADDR_W-1:0] addr;
    logic rd_stb;
    logic wr_stb;
    logic [DATA_W-1:0] host_data;
    logic host_data_oe;
    logic [DATA_W-1:0] dev_data;
    logic dev_data_oe;
    logic [DATA_W-1:0] data_bus;
    logic actuator_board_select_n;
    logic retract_latch_clear;
    logic carriage_unlock_drive;
    logic [DT_W-1:0] drive_type_gain_code_n;

    // bidirectional data bus level from the two enables
    assign data_bus = dev_data_oe ? dev_data : (host_data_oe ? host_data : '0);

    modport device (
        input addr, rd_stb, wr_stb, data_bus, retract_latch_clear,
        input carriage_unlock_drive, drive_type_gain_code_n,
        output dev_data, dev_data_oe, actuator_board_select_n
    );
    modport host (
        input data_bus, actuator_board_select_n,
        output addr, rd_stb, wr_stb, host_data, host_data_oe,
        output retract_latch_clear, carriage_unlock_drive, drive_type_gain_code_n
    );
endinterface : headpos_if

// ==== rtl/headpos_host.sv ====
// processor end: forwards register traffic, owns drive type, unlock pulse and latch clear
`timescale 1ns/100ps
module headpos_host
    import headpos_pkg::*;
#(
    parameter int CUL_CNT = CUL_CYCLES
) (
    // clock and reset
    input wire logic ref_clk_i,
    input wire logic reset_n_i,
    // software port
    input wire logic [ADDR_W-1:0] addr_i,
    input wire logic [DATA_W-1:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [DATA_W-1:0] rdata_o,
    // link
    headpos_if.host link
);
    logic local_sel;
    logic local_wr;
    logic [DT_W-1:0] dt_q;
    logic cul_q;
    logic [31:0] cul_cnt_q;
    logic rlc_q;
    logic local_rd_q;
    logic [DATA_W-1:0] local_rdata_q;
    logic [DATA_W-1:0] local_view;

    assign local_sel = (addr_i[ADDR_W-1:OFS_W] == HOST_PAGE)
                       && (addr_i[OFS_W-1:0] == REG_HOST_CTRL);
    assign local_wr = wr_i && local_sel;
    // register traffic to the positioner over the shared 8-bit bus
    assign link.addr = addr_i;
    assign link.wr_stb = wr_i && !local_sel;
    assign link.rd_stb = rd_i && !local_sel;
    assign link.host_data = wdata_i;
    assign link.host_data_oe = wr_i && !local_sel;
    assign link.drive_type_gain_code_n = ~dt_q;
    assign link.carriage_unlock_drive = cul_q;
    assign link.retract_latch_clear = rlc_q;
    assign local_view = {cul_q, 4'h0, dt_q};
    assign rdata_o = local_rd_q ? local_rdata_q : link.data_bus;

    always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            dt_q <= DT_RST;
            rlc_q <= 1'b0;
            local_rd_q <= 1'b0;
            local_rdata_q <= '0;
        end else begin
            if (local_wr) begin
                dt_q <= wdata_i[DT_W-1:0];
            end
            rlc_q <= local_wr && wdata_i[HC_RLC_BIT];
            local_rd_q <= rd_i && local_sel;
            local_rdata_q <= local_view;
        end
    end

    // unlock solenoid held only for the release time, then dropped
    always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            cul_q <= 1'b0;
            cul_cnt_q <= '0;
        end else if (local_wr && wdata_i[HC_CUL_BIT]) begin
            cul_q <= 1'b1;
            cul_cnt_q <= 32'(CUL_CNT - 1);
        end else if (cul_q) begin
            if (cul_cnt_q == '0) begin
                cul_q <= 1'b0;
            end else begin
                cul_cnt_q <= cul_cnt_q - 32'h0000_0001;
            end
        end
    end
endmodule : headpos_host

// ==== verif/headpos_link_properties.sv ====
// protocol checks on the link between the processor end and the positioner
`timescale 1ns/100ps
module headpos_link_properties
    import headpos_pkg::*;
(
    // clock and reset
    input wire logic ref_clk_i,
    input wire logic reset_n_i,
    // link signals
    input wire logic [ADDR_W-1:0] addr,
    input wire logic rd_stb,
    input wire logic wr_stb,
    input wire logic [DATA_W-1:0] host_data,
    input wire logic host_data_oe,
    input wire logic dev_data_oe,
    input wire logic [DATA_W-1:0] data_bus,
    input wire logic actuator_board_select_n,
    input wire logic retract_latch_clear,
    input wire logic carriage_unlock_drive
);
    default clocking cb @(posedge ref_clk_i);
    endclocking
    default disable iff (!reset_n_i);

    wire logic act_page = (addr[ADDR_W-1:OFS_W] == ACT_PAGE);
    wire logic dev_page = (addr[ADDR_W-1:OFS_W] == DEV_PAGE);

    sequence dev_read;
        rd_stb && dev_page;
    endsequence
    sequence unlock_start;
        $rose(carriage_unlock_drive);
    endsequence
    sequence unlock_hold;
        carriage_unlock_drive [*4] ##[1:12] !carriage_unlock_drive;
    endsequence

    act_sel_a: assert property (actuator_board_select_n == !act_page)
        else $error("actuator select does not follow the address page");
    read_drive_a: assert property (dev_read |=> dev_data_oe)
        else $error("device did not drive the bus after a read");
    drive_cause_a: assert property (dev_data_oe |-> $past(rd_stb))
        else $error("device drove the bus without a read");
    write_drive_a: assert property (wr_stb |-> host_data_oe)
        else $error("processor end not driving data on a write");
    write_bus_a: assert property (wr_stb && !dev_data_oe |-> data_bus == host_data)
        else $error("bus level differs from write data");
    strobe_excl_a: assert property (!(wr_stb && rd_stb))
        else $error("read and write strobes together");
    latch_clr_a: assert property (retract_latch_clear |=> !retract_latch_clear)
        else $error("retract latch clear longer than one cycle");
    unlock_pulse_a: assert property (unlock_start |-> unlock_hold)
        else $error("carriage unlock pulse length wrong");
endmodule : headpos_link_properties

// ==== verif/head_positioner_cpu_interface_test.sv ====
// self-checking bench for the processor end and positioner joined by their link
`timescale 1ns/100ps
module head_positioner_cpu_interface_test;
    import headpos_pkg::*;
    localparam int SEC_CYC = 4 * DIBIT_CYCLES;
    localparam int REV_CYC = 3 * SEC_CYC;
    // clock, reset and software port
    logic ref_clk_i = 1'b0;
    logic reset_n_i = 1'b0;
    logic [ADDR_W-1:0] sw_addr = '0;
    logic [DATA_W-1:0] sw_wdata = '0;
    logic sw_wr = 1'b0;
    logic sw_rd = 1'b0;
    logic [DATA_W-1:0] sw_rdata;
    // servo side
    logic dibit = 1'b0;
    logic qtc = 1'b0;
    logic sec_sync = 1'b0;
    logic gain_fault = 1'b0;
    logic head_good = 1'b0;
    logic [3:0] retract_src = '0;
    logic idx_n, sos_n, lin, fast_n, slow_n, tf_fault, ret_act;
    logic [DTG_W-1:0] distance_to_go_register;
    int err_total = 0;
    int cmp_count = 0;
    int idx_cnt = 0;
    int sos_cnt = 0;

    headpos_if link_if ();
    headpos_host #(.CUL_CNT(8)) u_headpos_host (.ref_clk_i(ref_clk_i), .reset_n_i(reset_n_i),
        .addr_i(sw_addr), .wdata_i(sw_wdata), .wr_i(sw_wr), .rd_i(sw_rd), .rdata_o(sw_rdata),
        .link(link_if));
    headpos_device #(.DIBITS_PER_SECTOR(4), .SECTORS_PER_REV(3)) u_headpos_device (
        .ref_clk_i(ref_clk_i), .reset_n_i(reset_n_i), .link(link_if), .servo_dibit_i(dibit),
        .sector_sync_i(sec_sync), .quarter_track_crossing_pulse_i(qtc), .gain_fault_i(gain_fault),
        .servo_head_good_i(head_good), .retract_src_i(retract_src), .index_pulse_n_o(idx_n),
        .sector_start_out_n_o(sos_n), .distance_to_go_o(distance_to_go_register), .linear_mode_o(lin),
        .fast_position_switch_enable_n_o(fast_n), .slow_position_switch_enable_n_o(slow_n),
        .track_follower_fault_o(tf_fault), .retract_active_o(ret_act));
    headpos_link_properties u_headpos_link_properties (.ref_clk_i(ref_clk_i),
        .reset_n_i(reset_n_i), .addr(link_if.addr), .rd_stb(link_if.rd_stb),
        .wr_stb(link_if.wr_stb), .host_data(link_if.host_data),
        .host_data_oe(link_if.host_data_oe), .dev_data_oe(link_if.dev_data_oe),
        .data_bus(link_if.data_bus), .actuator_board_select_n(link_if.actuator_board_select_n),
        .retract_latch_clear(link_if.retract_latch_clear),
        .carriage_unlock_drive(link_if.carriage_unlock_drive));

    initial begin
        forever #2.5 ref_clk_i = ~ref_clk_i;
    end

    // steady dibit stream keeps the timing chain locked
    initial begin
        forever begin
            repeat (DIBIT_CYCLES - 1) @(posedge ref_clk_i);
            dibit <= 1'b1;
            @(posedge ref_clk_i);
            dibit <= 1'b0;
        end
    end

    always @(posedge ref_clk_i) begin
        if (idx_n === 1'b0) idx_cnt++;
        if (sos_n === 1'b0) sos_cnt++;
    end

    task automatic report_and_stop();
        $display("comparisons %0d mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : report_and_stop

    task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string what);
        cmp_count++;
        if (seen !== exp) begin
            err_total++;
            $display("wrong value at %0t: %s saw %h expected %h", $time, what, seen, exp);
        end
    endtask : check

    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        @(posedge ref_clk_i);
        sw_addr <= a;
        sw_wdata <= d;
        sw_wr <= 1'b1;
        @(posedge ref_clk_i);
        sw_wr <= 1'b0;
    endtask : wr

    task automatic rd(input logic [11:0] a, input logic [7:0] m, input logic [7:0] e);
        @(posedge ref_clk_i);
        sw_addr <= a;
        sw_rd <= 1'b1;
        @(posedge ref_clk_i);
        sw_rd <= 1'b0;
        #1;
        check(16'(sw_rdata & m), 16'(e), "read data");
    endtask : rd

    task automatic qpulse(input int n);
        repeat (n) begin
            @(posedge ref_clk_i);
            qtc <= 1'b1;
            @(posedge ref_clk_i);
            qtc <= 1'b0;
            repeat (2) @(posedge ref_clk_i);
        end
    endtask : qpulse

    task automatic count(input int n);
        #1;
        idx_cnt = 0;
        sos_cnt = 0;
        repeat (n) @(posedge ref_clk_i);
        #1;
    endtask : count

    initial begin
        repeat (40000) @(posedge ref_clk_i);
        err_total++;
        $display("watchdog expired");
        report_and_stop();
    end

    initial begin
        repeat (2) @(posedge ref_clk_i);
        reset_n_i <= 1'b1;
        rd(12'h010, 8'hFF, TF_CTRL_RST);
        rd(12'h014, 8'hFF, SEEK_CTRL_RST);
        check(16'({lin, fast_n, slow_n}), 16'h0001, "drive mode");
        rd(12'h01F, 8'hFF, 8'h00);
        rd(12'h020, 8'hFF, 8'h00);
        check(16'(link_if.actuator_board_select_n), 16'h0000, "actuator select");
        $display("test reset and map done");
        wr(12'h012, 8'hA5);
        wr(12'h013, 8'h05);
        rd(12'h012, 8'hFF, 8'hA5);
        rd(12'h013, 8'h07, 8'h05);
        check(16'(distance_to_go_register), 16'h05A5, "distance");
        qpulse(4);
        check(16'(distance_to_go_register), 16'h05A5, "distance");
        wr(12'h014, 8'h0B);
        qpulse(3);
        check(16'(distance_to_go_register), 16'h05A2, "distance");
        wr(12'h014, 8'h09);
        wr(12'h012, 8'hA5);
        wr(12'h013, 8'h05);
        qpulse(4);
        check(16'(distance_to_go_register), 16'h05A3, "distance");
        wr(12'h012, 8'h01);
        wr(12'h013, 8'h00);
        wr(12'h014, 8'h0B);
        qpulse(3);
        check(16'(distance_to_go_register), 16'h0000, "distance");
        wr(12'h014, 8'h0C);
        #1;
        check(16'({lin, fast_n, slow_n}), 16'h0006, "drive mode");
        wr(12'h014, 8'h04);
        #1;
        check(16'({lin, fast_n, slow_n}), 16'h0007, "drive mode");
        wr(12'h014, 8'h08);
        $display("test seek counter and modes done");
        retract_src <= 4'h2;
        repeat (4) @(posedge ref_clk_i);
        #1;
        check(16'(ret_act), 16'h0001, "retract");
        @(posedge ref_clk_i);
        retract_src <= 4'h0;
        repeat (4) @(posedge ref_clk_i);
        rd(12'h015, 8'h07, 8'h07);
        wr(12'h015, 8'h01);
        rd(12'h015, 8'h07, 8'h06);
        check(16'(ret_act), 16'h0001, "retract");
        wr(12'h030, 8'h10);
        repeat (2) @(posedge ref_clk_i);
        rd(12'h015, 8'h07, 8'h00);
        check(16'(ret_act), 16'h0000, "retract");
        wr(12'h030, 8'h05);
        #1;
        check(16'(link_if.drive_type_gain_code_n), 16'h0002, "drive type");
        rd(12'h030, 8'h07, 8'h05);
        wr(12'h030, 8'h0D);
        rd(12'h030, 8'h80, 8'h80);
        repeat (20) @(posedge ref_clk_i);
        rd(12'h030, 8'h80, 8'h00);
        $display("test retract and host pins done");
        @(posedge ref_clk_i);
        gain_fault <= 1'b1;
        repeat (6) @(posedge ref_clk_i);
        gain_fault <= 1'b0;
        repeat (6) @(posedge ref_clk_i);
        rd(12'h011, 8'h30, 8'h30);
        check(16'(tf_fault), 16'h0001, "tf fault");
        wr(12'h010, 8'h01);
        wr(12'h010, 8'h00);
        rd(12'h011, 8'h30, 8'h00);
        @(posedge ref_clk_i);
        head_good <= 1'b1;
        repeat (4) @(posedge ref_clk_i);
        rd(12'h011, 8'h40, 8'h40);
        @(posedge ref_clk_i);
        head_good <= 1'b0;
        repeat (4) @(posedge ref_clk_i);
        rd(12'h011, 8'h40, 8'h00);
        // one sync mark, then none: sequencer must report a missed sector
        @(posedge ref_clk_i);
        sec_sync <= 1'b1;
        @(posedge ref_clk_i);
        sec_sync <= 1'b0;
        rd(12'h011, 8'h84, 8'h04);
        count(3 * SEC_CYC);
        rd(12'h011, 8'h84, 8'h84);
        wr(12'h010, 8'h01);
        wr(12'h010, 8'h00);
        rd(12'h011, 8'h84, 8'h00);
        $display("test status flags done");
        count(3 * REV_CYC);
        check(16'(idx_cnt), 16'd3, "index count");
        check(16'(sos_cnt), 16'd0, "sector count");
        wr(12'h010, 8'h04);
        count(REV_CYC);
        check(16'(sos_cnt), 16'd3, "sector count");
        check(16'(idx_cnt), 16'd1, "index count");
        wr(12'h010, 8'h06);
        repeat (2) @(posedge ref_clk_i);
        count(REV_CYC);
        check(16'(idx_cnt), 16'd0, "index count");
        wr(12'h010, 8'h05);
        count(SEC_CYC);
        rd(12'h011, 8'h03, 8'h02);
        wr(12'h010, 8'h04);
        count(SEC_CYC + 10);
        rd(12'h011, 8'h03, 8'h01);
        $display("test sector timing done");
        report_and_stop();
    end
endmodule : head_positioner_cpu_interface_test
